// ---- src/pmbus_setpoint_telemetry_formats.sv ----
// Set point, margin, soft start and telemetry formats of the power module command set
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module pmbus_setpoint_telemetry_formats #(
  parameter int HALF_MS_CYCLES = pmbus_fmt_pkg::TICK_CYCLES,
  parameter logic signed [7:0] TEMP_COEF = 8'sh00
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [15:0] adc_vout,
  input wire logic [10:0] adc_vin,
  input wire logic [10:0] adc_iout,
  input wire logic signed [10:0] adc_temp,
  input wire logic adc_valid,
  input wire logic sinking_pin,
  output logic [15:0] vout_target,
  output logic output_on,
  output logic ramping,
  output logic nvm_store,
  output logic data_invalid,
  output logic cmd_invalid
);
  typedef struct packed {
    logic [7:0] operation;
    logic [10:0] vin_on;
    logic [10:0] vin_off;
    logic [10:0] ton_delay;
    logic [10:0] ton_rise;
    logic [15:0] vout_cmd;
    logic [15:0] margin_high;
    logic [15:0] margin_low;
    logic [15:0] vout_trim;
    logic [10:0] vin_trim_off;
    logic [15:0] vin_gain;
    logic [10:0] iout_trim_off;
    logic [15:0] iout_gain;
    logic [15:0] read_vout;
    logic [10:0] read_vin;
    logic [10:0] read_iout;
    logic [10:0] read_temp;
    logic tele_pend;
    logic data_invalid;
    logic cmd_invalid;
    logic nvm_store;
    logic [15:0] rdata;
    logic [15:0] vout_target;
    pmbus_fmt_pkg::seq_e seq;
    logic output_on;
    logic ramping;
    logic [15:0] tick_cnt;
    logic [10:0] seq_cnt;
  } state_s;

  state_s s;
  state_s next_s;
  logic sinking;
  logic [10:0] mant;
  logic bad;
  logic tick;
  logic signed [16:0] vout_sum;
  logic signed [18:0] temp_prod;
  logic signed [15:0] iout_comp;

  trim_if vin_link ();
  trim_if iout_link ();

  pin_sync #(.WIDTH(1)) sink_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(sinking_pin),
    .sync_out(sinking)
  );

  trim_scale vin_scale (
    .clk_sys(clk_sys),
    .rst(rst),
    .port(vin_link.calc)
  );

  trim_scale iout_scale (
    .clk_sys(clk_sys),
    .rst(rst),
    .port(iout_link.calc)
  );

  assign vin_link.raw = adc_vin;
  assign vin_link.gain = s.vin_gain;
  assign vin_link.offset = s.vin_trim_off;
  assign iout_link.raw = adc_iout;
  assign iout_link.gain = s.iout_gain;
  assign iout_link.offset = s.iout_trim_off;

  always_comb begin
    next_s = s;
    next_s.nvm_store = 1'b0;
    next_s.rdata = 16'h0000;
    // Only the mantissa is taken; a written exponent field is ignored
    mant = wdata[10:0];
    bad = 1'b0;
    tick = (s.tick_cnt == 16'(HALF_MS_CYCLES - 1));
    next_s.tick_cnt = tick ? 16'h0000 : s.tick_cnt + 16'h0001;

    if (wr) begin
      if (addr == pmbus_fmt_pkg::CMD_OPERATION) begin
        if (wdata[5:4] == 2'h3) begin
          bad = 1'b1;
        end else begin
          next_s.operation = {wdata[7], 1'b0, wdata[5:4], pmbus_fmt_pkg::OP_FIXED_LOW};
        end
      end else if (addr == pmbus_fmt_pkg::CMD_CLEAR) begin
        next_s.data_invalid = 1'b0;
        next_s.cmd_invalid = 1'b0;
      end else if (addr == pmbus_fmt_pkg::CMD_STORE) begin
        next_s.nvm_store = 1'b1;
      end else if (addr == pmbus_fmt_pkg::CMD_VIN_ON) begin
        if (mant < pmbus_fmt_pkg::VIN_MIN || mant > pmbus_fmt_pkg::VIN_MAX
            || mant < s.vin_off + pmbus_fmt_pkg::VIN_HYST) begin
          bad = 1'b1;
        end else begin
          next_s.vin_on = mant;
        end
      end else if (addr == pmbus_fmt_pkg::CMD_VIN_OFF) begin
        if (mant < pmbus_fmt_pkg::VIN_MIN || mant > pmbus_fmt_pkg::VIN_MAX
            || mant + pmbus_fmt_pkg::VIN_HYST > s.vin_on) begin
          bad = 1'b1;
        end else begin
          next_s.vin_off = mant;
        end
      end else if (addr == pmbus_fmt_pkg::CMD_TON_DELAY) begin
        if (mant < pmbus_fmt_pkg::TON_DELAY_MIN || mant > pmbus_fmt_pkg::TON_MAX) begin
          bad = 1'b1;
        end else begin
          next_s.ton_delay = mant;
        end
      end else if (addr == pmbus_fmt_pkg::CMD_TON_RISE) begin
        if (mant < pmbus_fmt_pkg::TON_RISE_MIN || mant > pmbus_fmt_pkg::TON_MAX) begin
          bad = 1'b1;
        end else begin
          next_s.ton_rise = mant;
        end
      end else if (addr == pmbus_fmt_pkg::CMD_VOUT_COMMAND
                   || addr == pmbus_fmt_pkg::CMD_MARGIN_HIGH
                   || addr == pmbus_fmt_pkg::CMD_MARGIN_LOW) begin
        if (wdata < pmbus_fmt_pkg::VOUT_MIN || wdata > pmbus_fmt_pkg::VOUT_MAX) begin
          bad = 1'b1;
        end else if (addr == pmbus_fmt_pkg::CMD_VOUT_COMMAND) begin
          next_s.vout_cmd = wdata;
        end else if (addr == pmbus_fmt_pkg::CMD_MARGIN_HIGH) begin
          next_s.margin_high = wdata;
        end else begin
          next_s.margin_low = wdata;
        end
      end else if (addr == pmbus_fmt_pkg::CMD_VOUT_TRIM) begin
        next_s.vout_trim = wdata;
      end else if (addr == pmbus_fmt_pkg::CMD_VIN_TRIM_OFF) begin
        next_s.vin_trim_off = mant;
      end else if (addr == pmbus_fmt_pkg::CMD_VIN_TRIM_GAIN) begin
        next_s.vin_gain = wdata;
      end else if (addr == pmbus_fmt_pkg::CMD_IOUT_TRIM_OFF) begin
        next_s.iout_trim_off = mant;
      end else if (addr == pmbus_fmt_pkg::CMD_IOUT_TRIM_GAIN) begin
        next_s.iout_gain = wdata;
      end else begin
        next_s.cmd_invalid = 1'b1;
      end
      if (bad) begin
        next_s.data_invalid = 1'b1;
      end
    end

    if (rd) begin
      if (addr == pmbus_fmt_pkg::CMD_OPERATION) begin
        next_s.rdata = {8'h00, s.operation};
      end else if (addr == pmbus_fmt_pkg::CMD_VOUT_MODE) begin
        next_s.rdata = {8'h00, pmbus_fmt_pkg::VOUT_MODE_VAL};
      end else if (addr == pmbus_fmt_pkg::CMD_VOUT_COMMAND) begin
        next_s.rdata = s.vout_cmd;
      end else if (addr == pmbus_fmt_pkg::CMD_MARGIN_HIGH) begin
        next_s.rdata = s.margin_high;
      end else if (addr == pmbus_fmt_pkg::CMD_MARGIN_LOW) begin
        next_s.rdata = s.margin_low;
      end else if (addr == pmbus_fmt_pkg::CMD_VIN_ON) begin
        next_s.rdata = {pmbus_fmt_pkg::EXP_VIN, s.vin_on};
      end else if (addr == pmbus_fmt_pkg::CMD_VIN_OFF) begin
        next_s.rdata = {pmbus_fmt_pkg::EXP_VIN, s.vin_off};
      end else if (addr == pmbus_fmt_pkg::CMD_TON_DELAY) begin
        next_s.rdata = {pmbus_fmt_pkg::EXP_TON, s.ton_delay};
      end else if (addr == pmbus_fmt_pkg::CMD_TON_RISE) begin
        next_s.rdata = {pmbus_fmt_pkg::EXP_TON, s.ton_rise};
      end else if (addr == pmbus_fmt_pkg::CMD_STATUS_CML) begin
        next_s.rdata = {8'h00, s.cmd_invalid, s.data_invalid, 6'h00};
      end else if (addr == pmbus_fmt_pkg::CMD_READ_VIN) begin
        next_s.rdata = {pmbus_fmt_pkg::EXP_VIN, s.read_vin};
      end else if (addr == pmbus_fmt_pkg::CMD_READ_VOUT) begin
        next_s.rdata = s.read_vout;
      end else if (addr == pmbus_fmt_pkg::CMD_READ_IOUT) begin
        next_s.rdata = {pmbus_fmt_pkg::EXP_IOUT, s.read_iout};
      end else if (addr == pmbus_fmt_pkg::CMD_READ_TEMP) begin
        next_s.rdata = {pmbus_fmt_pkg::EXP_TEMP, s.read_temp};
      end else if (addr == pmbus_fmt_pkg::CMD_VOUT_TRIM) begin
        next_s.rdata = s.vout_trim;
      end else if (addr == pmbus_fmt_pkg::CMD_VIN_TRIM_OFF) begin
        next_s.rdata = {pmbus_fmt_pkg::EXP_VIN, s.vin_trim_off};
      end else if (addr == pmbus_fmt_pkg::CMD_VIN_TRIM_GAIN) begin
        next_s.rdata = s.vin_gain;
      end else if (addr == pmbus_fmt_pkg::CMD_IOUT_TRIM_OFF) begin
        next_s.rdata = {pmbus_fmt_pkg::EXP_IOUT, s.iout_trim_off};
      end else if (addr == pmbus_fmt_pkg::CMD_IOUT_TRIM_GAIN) begin
        next_s.rdata = s.iout_gain;
      end else begin
        next_s.cmd_invalid = 1'b1;
      end
    end

    // Telemetry: output voltage and temperature at once, scaled values one cycle later
    vout_sum = $signed({1'b0, adc_vout}) + $signed({s.vout_trim[15], s.vout_trim});
    next_s.tele_pend = adc_valid;
    if (adc_valid) begin
      if (vout_sum < 0) begin
        next_s.read_vout = 16'h0000;
      end else begin
        next_s.read_vout = vout_sum[15:0];
      end
      next_s.read_temp = adc_temp;
    end
    temp_prod = $signed(s.read_temp) * TEMP_COEF;
    iout_comp = iout_link.result
      + 16'(temp_prod >>> pmbus_fmt_pkg::TEMP_COMP_SHIFT);
    if (s.tele_pend) begin
      if (vin_link.result < 0) begin
        next_s.read_vin = 11'h000;
      end else if (vin_link.result > $signed({5'h00, pmbus_fmt_pkg::MANT_MAX})) begin
        next_s.read_vin = pmbus_fmt_pkg::MANT_MAX;
      end else begin
        next_s.read_vin = vin_link.result[10:0];
      end
      if (sinking || iout_comp < $signed({5'h00, pmbus_fmt_pkg::IOUT_BLANK_CNT})) begin
        next_s.read_iout = 11'h000;
      end else if (iout_comp > $signed({5'h00, pmbus_fmt_pkg::MANT_MAX})) begin
        next_s.read_iout = pmbus_fmt_pkg::MANT_MAX;
      end else begin
        next_s.read_iout = iout_comp[10:0];
      end
    end

    // Output target from the margin field of the operation byte
    case (s.operation[5:4])
      pmbus_fmt_pkg::MARGIN_LOW: next_s.vout_target = s.margin_low;
      pmbus_fmt_pkg::MARGIN_HIGH: next_s.vout_target = s.margin_high;
      default: next_s.vout_target = s.vout_cmd;
    endcase

    // Start-up: delay then ramp, both counted in half-millisecond ticks
    case (s.seq)
      pmbus_fmt_pkg::seq_off: begin
        next_s.seq_cnt = 11'h000;
        if (s.operation[7]) begin
          next_s.seq = pmbus_fmt_pkg::seq_delay;
        end
      end
      pmbus_fmt_pkg::seq_delay: begin
        if (tick) begin
          next_s.seq_cnt = s.seq_cnt + 11'h001;
          if (s.seq_cnt + 11'h001 >= s.ton_delay) begin
            next_s.seq = pmbus_fmt_pkg::seq_rise;
            next_s.seq_cnt = 11'h000;
          end
        end
      end
      pmbus_fmt_pkg::seq_rise: begin
        if (tick) begin
          next_s.seq_cnt = s.seq_cnt + 11'h001;
          if (s.seq_cnt + 11'h001 >= s.ton_rise) begin
            next_s.seq = pmbus_fmt_pkg::seq_on;
          end
        end
      end
      default: begin
        next_s.seq_cnt = 11'h000;
      end
    endcase
    if (!s.operation[7]) begin
      next_s.seq = pmbus_fmt_pkg::seq_off;
    end
    // Decoded from the next state so both outputs leave flip-flops in step with seq
    next_s.output_on = (next_s.seq == pmbus_fmt_pkg::seq_on);
    next_s.ramping = (next_s.seq == pmbus_fmt_pkg::seq_rise);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
      s.operation <= pmbus_fmt_pkg::OPERATION_RST;
      s.vin_on <= pmbus_fmt_pkg::VIN_ON_RST;
      s.vin_off <= pmbus_fmt_pkg::VIN_OFF_RST;
      s.ton_delay <= pmbus_fmt_pkg::TON_DELAY_RST;
      s.ton_rise <= pmbus_fmt_pkg::TON_RISE_RST;
      s.vout_cmd <= pmbus_fmt_pkg::VOUT_RST;
      s.margin_high <= pmbus_fmt_pkg::MARGIN_HIGH_RST;
      s.margin_low <= pmbus_fmt_pkg::MARGIN_LOW_RST;
      s.vin_gain <= pmbus_fmt_pkg::GAIN_RST;
      s.iout_gain <= pmbus_fmt_pkg::GAIN_RST;
      s.vout_target <= pmbus_fmt_pkg::VOUT_RST;
      s.seq <= pmbus_fmt_pkg::seq_off;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign vout_target = s.vout_target;
  assign output_on = s.output_on;
  assign ramping = s.ramping;
  assign nvm_store = s.nvm_store;
  assign data_invalid = s.data_invalid;
  assign cmd_invalid = s.cmd_invalid;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  vin_hyst_a: assert property (s.vin_on >= s.vin_off + pmbus_fmt_pkg::VIN_HYST)
    else $error("input thresholds closer than the hysteresis");
  vout_keep_a: assert property (wr && addr == pmbus_fmt_pkg::CMD_VOUT_COMMAND
    && wdata > pmbus_fmt_pkg::VOUT_MAX |=> $stable(s.vout_cmd) && data_invalid)
    else $error("out-of-range set point was taken");
  margin_target_a: assert property (s.operation[5:4] == pmbus_fmt_pkg::MARGIN_HIGH
    |=> vout_target == $past(s.margin_high))
    else $error("margin high not selected");
  store_pulse_a: assert property (wr && addr == pmbus_fmt_pkg::CMD_STORE ##1 !wr
    |-> nvm_store ##1 !nvm_store)
    else $error("store pulse wrong");
  vout_mode_a: assert property (rd && addr == pmbus_fmt_pkg::CMD_VOUT_MODE
    |=> rdata == {8'h00, pmbus_fmt_pkg::VOUT_MODE_VAL})
    else $error("output mode read wrong");
  iout_blank_a: assert property (s.read_iout == 11'h000
    || s.read_iout >= pmbus_fmt_pkg::IOUT_BLANK_CNT)
    else $error("current below blanking level reported");
  sink_zero_a: assert property (s.tele_pend && sinking |=> s.read_iout == 11'h000)
    else $error("sinking current not reported as zero");
  disable_off_a: assert property (!s.operation[7] |=> !output_on && !ramping)
    else $error("output not off while disabled");
  ton_range_a: assert property (s.ton_delay >= pmbus_fmt_pkg::TON_DELAY_MIN
    && s.ton_delay <= pmbus_fmt_pkg::TON_MAX && s.ton_rise >= pmbus_fmt_pkg::TON_RISE_MIN)
    else $error("start-up timing out of range");
  vout_read_a: assert property (adc_valid && adc_vout == 16'h1000 && s.vout_trim == 16'hFFF0
    |=> s.read_vout == 16'h0FF0)
    else $error("output voltage trim not applied");

  margin_low_c: cover property (vout_target == s.margin_low && s.operation[5:4] == 2'h1);
  ramp_c: cover property (ramping ##1 output_on);
  invalid_c: cover property ($rose(data_invalid));
  blank_c: cover property (s.tele_pend && !sinking ##1 s.read_iout == 11'h000);
endmodule : pmbus_setpoint_telemetry_formats

// ---- src/pmbus_fmt_pkg.sv ----
// Command codes, data formats, limits and timing for the set point and telemetry block
package pmbus_fmt_pkg;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_STORE = 8'h11;
  localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
  localparam logic [7:0] CMD_VOUT_COMMAND = 8'h21;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_VIN_ON = 8'h35;
  localparam logic [7:0] CMD_VIN_OFF = 8'h36;
  localparam logic [7:0] CMD_TON_DELAY = 8'h60;
  localparam logic [7:0] CMD_TON_RISE = 8'h61;
  localparam logic [7:0] CMD_STATUS_CML = 8'h7E;
  localparam logic [7:0] CMD_READ_VIN = 8'h88;
  localparam logic [7:0] CMD_READ_VOUT = 8'h8B;
  localparam logic [7:0] CMD_READ_IOUT = 8'h8C;
  localparam logic [7:0] CMD_READ_TEMP = 8'h8D;
  localparam logic [7:0] CMD_VOUT_TRIM = 8'hD0;
  localparam logic [7:0] CMD_VIN_TRIM_OFF = 8'hD1;
  localparam logic [7:0] CMD_VIN_TRIM_GAIN = 8'hD2;
  localparam logic [7:0] CMD_IOUT_TRIM_OFF = 8'hD3;
  localparam logic [7:0] CMD_IOUT_TRIM_GAIN = 8'hD4;
  // Five-bit two's complement exponent fields
  localparam logic [4:0] EXP_VIN = 5'h1D;
  localparam logic [4:0] EXP_TON = 5'h1F;
  localparam logic [4:0] EXP_IOUT = 5'h1C;
  localparam logic [4:0] EXP_TEMP = 5'h1E;
  localparam logic [7:0] VOUT_MODE_VAL = 8'h14;
  localparam logic [10:0] VIN_MIN = 11'h100;
  localparam logic [10:0] VIN_MAX = 11'h170;
  localparam logic [10:0] VIN_HYST = 11'h010;
  localparam logic [10:0] TON_DELAY_MIN = 11'h014;
  localparam logic [10:0] TON_RISE_MIN = 11'h01E;
  localparam logic [10:0] TON_MAX = 11'h3E8;
  localparam logic [15:0] VOUT_MIN = 16'h819A;
  localparam logic [15:0] VOUT_MAX = 16'hD333;
  localparam logic [10:0] MANT_MAX = 11'h3FF;
  localparam logic [7:0] OPERATION_RST = 8'h88;
  localparam logic [1:0] MARGIN_OFF = 2'h0;
  localparam logic [1:0] MARGIN_LOW = 2'h1;
  localparam logic [1:0] MARGIN_HIGH = 2'h2;
  localparam logic [3:0] OP_FIXED_LOW = 4'h8;
  localparam logic [10:0] VIN_ON_RST = 11'h110;
  localparam logic [10:0] VIN_OFF_RST = 11'h100;
  localparam logic [10:0] TON_DELAY_RST = 11'h014;
  localparam logic [10:0] TON_RISE_RST = 11'h01E;
  localparam logic [15:0] VOUT_RST = 16'hC000;
  localparam logic [15:0] MARGIN_HIGH_RST = 16'hCCCD;
  localparam logic [15:0] MARGIN_LOW_RST = 16'hB333;
  localparam logic [15:0] GAIN_RST = 16'h2000;
  localparam int GAIN_SHIFT = 13;
  localparam int TEMP_COMP_SHIFT = 8;
  localparam int IOUT_BLANK_MA = 1650;
  localparam int IOUT_LSB_UA = 62500;
  localparam logic [10:0] IOUT_BLANK_CNT =
    11'((IOUT_BLANK_MA * 1000 + IOUT_LSB_UA - 1) / IOUT_LSB_UA);
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_MS_NS = 500000;
  localparam int TICK_CYCLES = HALF_MS_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {seq_off, seq_delay, seq_rise, seq_on} seq_e;
endpackage : pmbus_fmt_pkg

// ---- src/trim_if.sv ----
// Raw reading, trim gain and offset, and the corrected result between scaler and core
`timescale 1ns/1ps
interface trim_if;
  logic [10:0] raw;
  logic [15:0] gain;
  logic signed [10:0] offset;
  logic signed [15:0] result;
  modport src (output raw, output gain, output offset, input result);
  modport calc (input raw, input gain, input offset, output result);
endinterface : trim_if

// ---- src/pin_sync.sv ----
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } state_s;
  state_s s;
  state_s next_s;
  always_comb begin
    next_s.meta = async_in;
    next_s.stable = s.meta;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign sync_out = s.stable;
endmodule : pin_sync

// ---- src/trim_scale.sv ----
// Gain and offset correction: raw times gain over 8192 plus signed offset, one cycle
`timescale 1ns/1ps
module trim_scale (
  input wire logic clk_sys,
  input wire logic rst,
  trim_if.calc port
);
  typedef struct packed {
    logic signed [15:0] result;
  } state_s;
  state_s s;
  state_s next_s;
  logic [26:0] product;
  always_comb begin
    product = {5'h00, port.raw} * {11'h000, port.gain};
    next_s.result = $signed({2'h0, product[26:pmbus_fmt_pkg::GAIN_SHIFT]})
      + {{5{port.offset[10]}}, port.offset};
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign port.result = s.result;
endmodule : trim_scale

// ---- tb/adc_feed.sv ----
// Converter-side model: raw readings and the current-direction level
`timescale 1ns/1ps
module adc_feed (
  input wire logic clk_sys,
  input wire logic req,
  input wire logic [15:0] v_out,
  input wire logic [10:0] v_in,
  input wire logic [10:0] i_out,
  input wire logic [10:0] temp,
  input wire logic sink,
  output logic [15:0] adc_vout,
  output logic [10:0] adc_vin,
  output logic [10:0] adc_iout,
  output logic signed [10:0] adc_temp,
  output logic adc_valid,
  output logic sinking_pin
);
  initial begin
    {adc_vout, adc_vin, adc_iout, adc_temp, adc_valid, sinking_pin} = '0;
  end
  // Readings stay put after the strobe; the design samples them all at the strobe edge and scales vin and iout one edge later
  always @(posedge clk_sys) begin
    adc_valid <= req;
    sinking_pin <= sink;
    if (req) begin
      {adc_vout, adc_vin, adc_iout, adc_temp} <= {v_out, v_in, i_out, temp};
    end
  end
endmodule : adc_feed

// ---- tb/pmbus_setpoint_telemetry_formats_tb.sv ----
// Self-checking bench for the set point and telemetry block
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin tests_run++; if ((sn) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, ex, sn); end end
module pmbus_setpoint_telemetry_formats_tb;
  logic clk_sys = 0, rst = 1, wr = 0, rd = 0, req = 0, sink = 0;
  logic [7:0] addr = '0;
  logic [15:0] wdata = '0, rdata, vout_target, adc_vout, v_out = '0, got;
  logic [10:0] adc_vin, adc_iout, v_in = '0, i_out = '0, temp = '0;
  logic signed [10:0] adc_temp;
  logic adc_valid, sinking_pin, output_on, ramping, nvm_store, data_invalid, cmd_invalid;
  int mismatches = 0, tests_run = 0, cycles = 0, stores = 0, n;
  always #5 clk_sys = ~clk_sys;
  pmbus_setpoint_telemetry_formats #(.HALF_MS_CYCLES(10), .TEMP_COEF(8'sh10))
    i_pmbus_setpoint_telemetry_formats (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .adc_vout(adc_vout), .adc_vin(adc_vin), .adc_iout(adc_iout),
    .adc_temp(adc_temp), .adc_valid(adc_valid), .sinking_pin(sinking_pin),
    .vout_target(vout_target), .output_on(output_on), .ramping(ramping),
    .nvm_store(nvm_store), .data_invalid(data_invalid), .cmd_invalid(cmd_invalid));
  adc_feed i_adc_feed (.clk_sys(clk_sys), .req(req), .v_out(v_out), .v_in(v_in),
    .i_out(i_out), .temp(temp), .sink(sink), .adc_vout(adc_vout), .adc_vin(adc_vin),
    .adc_iout(adc_iout), .adc_temp(adc_temp), .adc_valid(adc_valid),
    .sinking_pin(sinking_pin));
  always @(posedge clk_sys) begin
    if (nvm_store === 1'b1) stores++;
    cycles++;
    // Whole run needs under 3000 cycles
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  // Extra edge lets registered outputs such as vout_target settle
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys);
    rd <= 1'b1; addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] ex);
    rd_reg(a);
    `CHK("rdata", ex, got)
  endtask : rd_chk
  task automatic bad_wr(input logic [7:0] a, input logic [15:0] d);
    wr_reg(a, d);
    `CHK("data_invalid", 1'b1, data_invalid)
    wr_reg(8'h03, 16'h0000);
    `CHK("data_invalid clear", 1'b0, data_invalid)
  endtask : bad_wr
  task automatic feed(input logic [15:0] vo, input logic [10:0] vi, io, tp, input logic s);
    @(posedge clk_sys);
    req <= 1'b1; v_out <= vo; v_in <= vi; i_out <= io; temp <= tp; sink <= s;
    @(posedge clk_sys);
    req <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : feed
  task automatic t_reset();
    `CHK("vout_target", 16'hC000, vout_target)
    `CHK("output_on", 1'b0, output_on)
    rd_chk(8'h20, 16'h0014);
  endtask : t_reset
  task automatic t_setpoint();
    wr_reg(8'h21, 16'hD333);
    `CHK("vout_target", 16'hD333, vout_target)
    wr_reg(8'h21, 16'hD334);
    `CHK("vout_target", 16'hD333, vout_target)
    rd_chk(8'h7E, 16'h0040);
    wr_reg(8'h03, 16'h0000);
    bad_wr(8'h21, 16'h8199);
    wr_reg(8'h21, 16'h819A);
    `CHK("vout_target", 16'h819A, vout_target)
  endtask : t_setpoint
  task automatic t_margin();
    logic [15:0] op [4] = '{16'h0098, 16'h00A8, 16'h0084, 16'h0088};
    logic [15:0] ex [4] = '{16'hB000, 16'hCC00, 16'h819A, 16'h819A};
    wr_reg(8'h26, 16'hB000);
    wr_reg(8'h25, 16'hCC00);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h01, op[i]);
      `CHK("vout_target", ex[i], vout_target)
    end
    bad_wr(8'h01, 16'h00B8);
  endtask : t_margin
  task automatic t_linear();
    wr_reg(8'h35, 16'h0120);
    rd_chk(8'h35, 16'hE920);
    bad_wr(8'h36, 16'h00FF);
    bad_wr(8'h36, 16'h0118);
    bad_wr(8'h35, 16'h0171);
    rd_chk(8'h36, 16'hE900);
    bad_wr(8'h60, 16'h0013);
    bad_wr(8'h61, 16'h001D);
    wr_reg(8'h60, 16'hF814);
    rd_chk(8'h61, 16'hF81E);
    rd_chk(8'h60, 16'hF814);
  endtask : t_linear
  task automatic t_telemetry();
    wr_reg(8'hD0, 16'hFFF0);
    feed(16'h1000, 11'h120, 11'h040, 11'h7FB, 1'b0);
    rd_chk(8'h8B, 16'h0FF0);
    rd_chk(8'h88, 16'hE920);
    rd_chk(8'h8C, 16'hE03F);
    rd_chk(8'h8D, 16'hF7FB);
    wr_reg(8'hD2, 16'h4000);
    wr_reg(8'hD1, 16'hE808);
    rd_chk(8'hD1, 16'hE808);
    wr_reg(8'hD4, 16'h4000);
    wr_reg(8'hD3, 16'hE002);
    rd_chk(8'hD3, 16'hE002);
    feed(16'h1000, 11'h120, 11'h00C, 11'h000, 1'b0);
    rd_chk(8'h88, 16'hEA48);
    rd_chk(8'h8C, 16'hE000);
    feed(16'h1000, 11'h120, 11'h00D, 11'h000, 1'b0);
    rd_chk(8'h8C, 16'hE01C);
    feed(16'h1000, 11'h120, 11'h040, 11'h000, 1'b1);
    feed(16'h1000, 11'h120, 11'h040, 11'h000, 1'b1);
    rd_chk(8'h8C, 16'hE000);
  endtask : t_telemetry
  task automatic t_startup();
    wr_reg(8'h01, 16'h0000);
    `CHK("output_on", 1'b0, output_on)
    wr_reg(8'h01, 16'h0080);
    n = 0;
    while (ramping !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK("delay window", 1'b1, n >= 190 && n <= 210)
    n = 0;
    while (output_on !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK("rise window", 1'b1, n >= 290 && n <= 310)
    wr_reg(8'h01, 16'h0000);
    `CHK("output_on", 1'b0, output_on)
  endtask : t_startup
  task automatic t_store();
    `CHK("store pulses", 0, stores)
    wr_reg(8'h11, 16'h0000);
    repeat (2) @(posedge clk_sys);
    `CHK("store pulses", 1, stores)
    rd_chk(8'h02, 16'h0000);
    `CHK("cmd_invalid", 1'b1, cmd_invalid)
  endtask : t_store
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_setpoint();
    t_margin();
    t_linear();
    t_telemetry();
    t_startup();
    t_store();
    conclude();
  end
endmodule : pmbus_setpoint_telemetry_formats_tb
